// ### tsrs_pkg.sv
// Constants for the temperature sensor register set
package tsrs_pkg;
    localparam logic [5:0]  REG_DEVNUM   = 6'h00;
    localparam logic [5:0]  REG_MAKER    = 6'h01;
    localparam logic [5:0]  REG_PART     = 6'h02;
    localparam logic [5:0]  REG_FUNCCAP  = 6'h03;
    localparam logic [5:0]  REG_STATUS   = 6'h04;
    localparam logic [5:0]  REG_DEVCTL   = 6'h05;
    localparam logic [5:0]  REG_TEMPCAP  = 6'h08;
    localparam logic [5:0]  REG_RESULT   = 6'h09;
    localparam logic [5:0]  REG_TEMPCTL  = 6'h0a;
    localparam logic [5:0]  REG_CONVRATE = 6'h20;
    localparam int          ADDR_W       = 6;
    localparam int          DATA_W       = 16;
    localparam logic [2:0]  DEVNUM_BCAST = 3'h0;
    localparam logic [15:0] FUNCCAP_VAL  = 16'h0001;
    localparam logic [15:0] TEMPCAP_VAL  = 16'h014a;
    localparam int          ST_BER       = 7;
    localparam int          ST_OVERRUN_FLAG      = 4;
    localparam int          ST_DONE      = 0;
    localparam int          DC_FUNCTION_ENABLE      = 4;
    localparam int          DC_LOWPWR    = 2;
    localparam int          DC_SHUT      = 1;
    localparam int          DC_RST       = 0;
    localparam int          TC_ENS       = 1;
    localparam int          TC_ATE       = 0;
    localparam int          RES_LSB      = 6;
    localparam logic [4:0]  DEVCTL_RST   = 5'h00;
    localparam logic [1:0]  TEMPCTL_RST  = 2'h0;
    localparam logic [1:0]  RATE_RST     = 2'h2;
    localparam int          CLK_KHZ      = 40000;
    localparam int          CONV_MS_00   = 64;
    localparam int          CONV_MS_01   = 96;
    localparam int          CONV_MS_10   = 190;
    localparam int          CONV_MS_11   = 382;
    localparam int          CONV_MS_L00  = 96;
    localparam int          CONV_MS_L01  = 382;
    localparam int          CONV_MS_L10  = 766;
    localparam int          CONV_MS_L11  = 1532;
    localparam int          CNT_W        = 32;
    typedef enum logic [1:0]
    {
        CV_IDLE = 2'b00,
        CV_RUN  = 2'b01,
        CV_WAIT = 2'b10
    } tsrs_conv_t;
endpackage

// ### tsrs_regs.sv
// Register set, status flags and conversion timing of the temperature sensor
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - Address pins 00/01/10/11 give device number 1/2/3/4, upper bits zero.
// - Device number zero is broadcast; broadcast reads get no answer.
// - Broadcast write touches only shutdown and reset bits of device control.
// - Part identity holds part code in 10:0 and die revision in 15:11.
// - Function capabilities read constant one.
// - Bus error flag bit 7 sets on acknowledge error, clears on status read.
// - Overrun flag bit 4 sets on unread result overwrite, clears on result read.
// - Done flag bit 0 sets when a result is stored, clears on result read.
// - Conversions run only with function enable and sensor enable, both default zero.
// - A write replaces the whole register; master supplies every bit.
// - Low-power bit slows all functions; clear means normal speed.
// - Shutdown disables all functions until a zero is written there.
// - Reset bit aborts work, restores defaults, then clears itself.
// - Temperature capabilities read constant 014a.
// - Result is 10-bit two's complement in 15:6, low bits zero.
// - With attention and sensor enables set, a new status bit requests attention.
// - Bus error always requests attention; conversion requests have extra conditions.
// - Conversion time follows low-power bit and rate field; rate default 10.
// - Conversion attention only with bus idle and none since last status read.
// - An unacknowledged write changes nothing.
module tsrs_regs
#(
    parameter logic [4:0]  DIE_REVISION = 5'h00,
    parameter logic [10:0] PART_CODE    = 11'h123,  // Arbitrary value
    parameter logic [15:0] MAKER_CODE   = 16'h5a5a, // Arbitrary value
    parameter int          CONV_MS_00_P = tsrs_pkg::CONV_MS_00 * tsrs_pkg::CLK_KHZ,
    parameter int          CONV_MS_01_P = tsrs_pkg::CONV_MS_01 * tsrs_pkg::CLK_KHZ,
    parameter int          CONV_MS_10_P = tsrs_pkg::CONV_MS_10 * tsrs_pkg::CLK_KHZ,
    parameter int          CONV_MS_11_P = tsrs_pkg::CONV_MS_11 * tsrs_pkg::CLK_KHZ,
    parameter int          CONV_L00_P   = tsrs_pkg::CONV_MS_L00 * tsrs_pkg::CLK_KHZ,
    parameter int          CONV_L01_P   = tsrs_pkg::CONV_MS_L01 * tsrs_pkg::CLK_KHZ,
    parameter int          CONV_L10_P   = tsrs_pkg::CONV_MS_L10 * tsrs_pkg::CLK_KHZ,
    parameter int          CONV_L11_P   = tsrs_pkg::CONV_MS_L11 * tsrs_pkg::CLK_KHZ
)
(
    input  wire logic                          mclk,
    input  wire logic                          arst_n,
    input  wire logic                          clk_en,
    input  wire logic                          addr_pin_high,
    input  wire logic                          addr_pin_low,
    input  wire logic [2:0]                    bus_dev,
    input  wire logic [tsrs_pkg::ADDR_W-1:0]   bus_addr,
    input  wire logic [tsrs_pkg::DATA_W-1:0]   bus_wdata,
    input  wire logic                          bus_wr,
    input  wire logic                          bus_rd,
    input  wire logic                          bus_ack_ok,
    input  wire logic                          bus_ack_err,
    input  wire logic                          bus_idle,
    input  wire logic [9:0]                    sensor_code,
    output logic [tsrs_pkg::DATA_W-1:0]        bus_rdata,
    output logic                               bus_rvalid,
    output logic                               attn_req,
    output logic                               conv_active,
    output logic                               low_speed
);
    import tsrs_pkg::*;

    logic [2:0]  pin_hi_s_q;
    logic [2:0]  pin_lo_s_q;
    logic [1:0]  pins_q;
    logic [7:0]  device_number_q;
    logic [4:0]  device_control_q;
    logic [1:0]  temperature_control_q;
    logic [1:0]  rate_q;
    logic [9:0]  result_q;
    logic        bus_error_flag_q;
    logic        overrun_flag_q;
    logic        conversion_done_flag_q;
    logic        attn_pending_q;
    logic        soft_rst_q;
    tsrs_conv_t  conv_q;
    logic [CNT_W-1:0] conv_cnt_q;
    logic [CNT_W-1:0] conv_len;
    logic        addressed;
    logic        bcast;
    logic        wr_ok;
    logic        rd_ok;
    logic        conv_run;
    logic        conv_done;
    logic        rd_status;
    logic        rd_result;
    logic [7:0]  status_byte;

    function automatic logic [7:0] devnum_of(input logic [1:0] pins);
        devnum_of = {5'h00, {1'b0, pins} + 3'h1};
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    // Pins are asynchronous; accept a change once stages two and three agree
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_hi_s_q <= 3'h0;
            pin_lo_s_q <= 3'h0;
            pins_q     <= 2'h0;
        end
        else if (clk_en)
        begin
            pin_hi_s_q <= {pin_hi_s_q[1:0], addr_pin_high};
            pin_lo_s_q <= {pin_lo_s_q[1:0], addr_pin_low};
            if (pin_hi_s_q[1] == pin_hi_s_q[2])
                pins_q[1] <= pin_hi_s_q[2];
            if (pin_lo_s_q[1] == pin_lo_s_q[2])
                pins_q[0] <= pin_lo_s_q[2];
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            device_number_q <= 8'h01;
        else if (clk_en)
            device_number_q <= devnum_of(pins_q);
    end

    assign bcast     = (bus_dev == DEVNUM_BCAST);
    assign addressed = (bus_dev == device_number_q[2:0]);
    assign wr_ok     = bus_wr && bus_ack_ok && !bus_ack_err;
    assign rd_ok     = bus_rd && addressed;
    assign rd_status = rd_ok && hit(bus_addr, REG_STATUS);
    assign rd_result = rd_ok && hit(bus_addr, REG_RESULT);

    // Shutdown and pending reset both stop every function
    assign conv_run  = device_control_q[DC_FUNCTION_ENABLE] && temperature_control_q[TC_ENS]
                       && !device_control_q[DC_SHUT] && !soft_rst_q;

    always_comb
    begin
        case ({device_control_q[DC_LOWPWR], rate_q})
            3'h0:    conv_len = CNT_W'(CONV_MS_00_P);
            3'h1:    conv_len = CNT_W'(CONV_MS_01_P);
            3'h2:    conv_len = CNT_W'(CONV_MS_10_P);
            3'h3:    conv_len = CNT_W'(CONV_MS_11_P);
            3'h4:    conv_len = CNT_W'(CONV_L00_P);
            3'h5:    conv_len = CNT_W'(CONV_L01_P);
            3'h6:    conv_len = CNT_W'(CONV_L10_P);
            default: conv_len = CNT_W'(CONV_L11_P);
        endcase
    end

    // Gated by the enables so a shutdown in the last cycle stores nothing
    assign conv_done = (conv_q == CV_RUN) && (conv_cnt_q == CNT_W'(1)) && conv_run;

    // Control registers; whole-register writes only, broadcast hits reset/shutdown
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            device_control_q      <= DEVCTL_RST;
            temperature_control_q <= TEMPCTL_RST;
            rate_q                <= RATE_RST;
            soft_rst_q            <= 1'b0;
        end
        else if (clk_en)
        begin
            if (soft_rst_q)
            begin
                device_control_q      <= DEVCTL_RST;
                temperature_control_q <= TEMPCTL_RST;
                rate_q                <= RATE_RST;
                soft_rst_q            <= 1'b0;
            end
            else if (wr_ok && bcast && hit(bus_addr, REG_DEVCTL))
            begin
                device_control_q[1:0] <= bus_wdata[1:0];
                soft_rst_q            <= bus_wdata[DC_RST];
            end
            else if (wr_ok && addressed)
            begin
                if (hit(bus_addr, REG_DEVCTL))
                begin
                    device_control_q <= {bus_wdata[4], 1'b0, bus_wdata[2:0]};
                    soft_rst_q       <= bus_wdata[DC_RST];
                end
                if (hit(bus_addr, REG_TEMPCTL))
                    temperature_control_q <= bus_wdata[1:0];
                if (hit(bus_addr, REG_CONVRATE))
                    rate_q <= bus_wdata[1:0];
            end
        end
    end

    // Conversion timer; restarts from the top whenever it is stopped
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            conv_q     <= CV_IDLE;
            conv_cnt_q <= '0;
        end
        else if (clk_en)
        begin
            case (conv_q)
                CV_IDLE:
                begin
                    if (conv_run)
                    begin
                        conv_q     <= CV_RUN;
                        conv_cnt_q <= conv_len;
                    end
                end
                CV_RUN:
                begin
                    if (!conv_run)
                        conv_q <= CV_IDLE;
                    else if (conv_done)
                        conv_q <= CV_WAIT;
                    else
                        conv_cnt_q <= conv_cnt_q - CNT_W'(1);
                end
                CV_WAIT:
                    conv_q <= CV_IDLE;
                default:
                    conv_q <= CV_IDLE;
            endcase
        end
    end

    // Result captured whole in one edge so a read never sees a mix
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            result_q <= 10'h000;
        else if (clk_en)
        begin
            if (soft_rst_q)
                result_q <= 10'h000;
            else if (conv_done)
                result_q <= sensor_code;
        end
    end

    // Status flags: a set in the same cycle as its clearing read wins
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_error_flag_q       <= 1'b0;
            overrun_flag_q         <= 1'b0;
            conversion_done_flag_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (soft_rst_q)
            begin
                overrun_flag_q         <= 1'b0;
                conversion_done_flag_q <= 1'b0;
                bus_error_flag_q       <= bus_ack_err;
            end
            else
            begin
                if (bus_ack_err)
                    bus_error_flag_q <= 1'b1;
                else if (rd_status)
                    bus_error_flag_q <= 1'b0;
                if (conv_done && conversion_done_flag_q)
                    overrun_flag_q <= 1'b1;
                else if (rd_result)
                    overrun_flag_q <= 1'b0;
                if (conv_done)
                    conversion_done_flag_q <= 1'b1;
                else if (rd_result)
                    conversion_done_flag_q <= 1'b0;
            end
        end
    end

    // Attention: bus error always; conversion gated by enables, idle bus, no pending
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            attn_req       <= 1'b0;
            attn_pending_q <= 1'b0;
        end
        else if (clk_en)
        begin
            attn_req <= 1'b0;
            if (bus_ack_err)
            begin
                attn_req       <= 1'b1;
                attn_pending_q <= 1'b1;
            end
            else if (conv_done && temperature_control_q[TC_ATE]
                     && temperature_control_q[TC_ENS] && bus_idle
                     && !attn_pending_q)
            begin
                attn_req       <= 1'b1;
                attn_pending_q <= 1'b1;
            end
            else if (rd_status || soft_rst_q)
                attn_pending_q <= 1'b0;
        end
    end

    assign status_byte = {bus_error_flag_q, 2'h0, overrun_flag_q, 3'h0,
                          conversion_done_flag_q};

    // Read port; unmapped offsets read zero, broadcast reads stay silent
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_rdata  <= 16'h0000;
            bus_rvalid <= 1'b0;
        end
        else if (clk_en)
        begin
            bus_rvalid <= rd_ok;
            if (!rd_ok)
                bus_rdata <= 16'h0000;
            else
            begin
                case (bus_addr)
                    REG_DEVNUM:   bus_rdata <= {8'h00, device_number_q};
                    REG_MAKER:    bus_rdata <= MAKER_CODE;
                    REG_PART:     bus_rdata <= {DIE_REVISION, PART_CODE};
                    REG_FUNCCAP:  bus_rdata <= FUNCCAP_VAL;
                    REG_STATUS:   bus_rdata <= {8'h00, status_byte};
                    REG_DEVCTL:   bus_rdata <= {11'h000, device_control_q};
                    REG_TEMPCAP:  bus_rdata <= TEMPCAP_VAL;
                    REG_RESULT:   bus_rdata <= {result_q, 6'h00};
                    REG_TEMPCTL:  bus_rdata <= {14'h0000, temperature_control_q};
                    REG_CONVRATE: bus_rdata <= {14'h0000, rate_q};
                    default:      bus_rdata <= 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            conv_active <= 1'b0;
            low_speed   <= 1'b0;
        end
        else if (clk_en)
        begin
            conv_active <= (conv_q == CV_RUN);
            low_speed   <= device_control_q[DC_LOWPWR];
        end
    end
endmodule

// ### tsrs_master.sv
// Bus master model that drives the register set access port
`timescale 1ns/1ps
module tsrs_master
(
    input  wire logic [tsrs_pkg::DATA_W-1:0] bus_rdata,
    input  wire logic                        bus_rvalid,
    input  wire logic                        mclk,
    output logic [2:0]                       bus_dev,
    output logic [tsrs_pkg::ADDR_W-1:0]      bus_addr,
    output logic [tsrs_pkg::DATA_W-1:0]      bus_wdata,
    output logic                             bus_wr,
    output logic                             bus_rd,
    output logic                             bus_ack_ok,
    output logic                             bus_ack_err,
    output logic                             bus_idle
);
    import tsrs_pkg::*;
    initial
    begin
        {bus_dev, bus_addr, bus_wdata, bus_wr, bus_rd, bus_ack_ok, bus_ack_err} = '0;
        bus_idle = 1'b1;
    end
    task automatic wr(input logic [2:0] dv, input logic [5:0] a, input logic [15:0] w,
                      input logic ok);
        @(posedge mclk);
        bus_dev    <= dv;
        bus_addr   <= a;
        bus_wdata  <= w;   // Whole word on every write
        bus_ack_ok <= ok;  // Unacknowledged writes on demand
        bus_wr     <= 1'b1;
        @(posedge mclk);
        bus_wr     <= 1'b0;
        bus_ack_ok <= 1'b0;
        bus_wdata  <= ~w;  // Stale data must not look valid
    endtask
    task automatic rd(input logic [2:0] dv, input logic [5:0] a, output logic [15:0] q,
                      output logic vq);
        @(posedge mclk);
        bus_dev  <= dv;
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_rd   <= 1'b0;
        #1;
        q  = bus_rdata;
        vq = bus_rvalid;
    endtask
    task automatic idle(input logic b);
        @(posedge mclk);
        bus_idle <= b;
    endtask
    task automatic berr();
        @(posedge mclk);
        bus_ack_err <= 1'b1;
        @(posedge mclk);
        bus_ack_err <= 1'b0;
    endtask
endmodule

// ### tsrs_regs_assertions.sv
// Port checks for the temperature sensor register set
`timescale 1ns/1ps
module tsrs_regs_chk
(
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        clk_en,
    input wire logic        addr_pin_high,
    input wire logic        addr_pin_low,
    input wire logic [2:0]  bus_dev,
    input wire logic [5:0]  bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic        bus_ack_ok,
    input wire logic        bus_ack_err,
    input wire logic        bus_idle,
    input wire logic [9:0]  sensor_code,
    input wire logic [15:0] bus_rdata,
    input wire logic        bus_rvalid,
    input wire logic        attn_req,
    input wire logic        conv_active,
    input wire logic        low_speed
);
    import tsrs_pkg::*;
    logic [2:0] own_dev;
    logic       dc_wr;
    assign own_dev = {1'b0, addr_pin_high, addr_pin_low} + 3'h1;
    assign dc_wr = clk_en && bus_wr && bus_ack_ok && bus_addr == REG_DEVCTL;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence rd_at(logic [5:0] a);
        clk_en && bus_rd && bus_dev == own_dev && bus_addr == a;
    endsequence
    read_answer_a: assert property (clk_en && bus_rd && bus_dev == own_dev |=> bus_rvalid)
        else $error("addressed read got no answer");
    devnum_value_a: assert property (rd_at(REG_DEVNUM) |=> bus_rdata == {13'h0, own_dev})
        else $error("device number mismatch");
    bcast_read_a: assert property (clk_en && bus_rd && bus_dev == DEVNUM_BCAST
        |=> !bus_rvalid)
        else $error("broadcast read answered");
    rvalid_cause_a: assert property (bus_rvalid |-> $past(bus_rd && clk_en))
        else $error("read data without read");
    funccap_const_a: assert property (rd_at(REG_FUNCCAP) |=> bus_rdata == 16'h0001)
        else $error("function capabilities wrong");
    tempcap_const_a: assert property (rd_at(REG_TEMPCAP) |=> bus_rdata == 16'h014a)
        else $error("temperature capabilities wrong");
    result_low_a: assert property (rd_at(REG_RESULT) |=> bus_rdata[5:0] == 6'h00)
        else $error("result low bits not zero");
    status_resv_a: assert property (rd_at(REG_STATUS)
        |=> (bus_rdata & 16'hff6e) == 16'h0000)
        else $error("status reserved bits set");
    // Control register lands one edge before its copy on the pin
    lowpwr_copy_a: assert property (dc_wr && bus_dev == own_dev && !bus_wdata[DC_RST]
        |=> ##1 low_speed == $past(bus_wdata[DC_LOWPWR], 2))
        else $error("low speed does not follow control");
    berr_attn_a: assert property (clk_en && bus_ack_err |-> ##[1:3] attn_req)
        else $error("bus error raised no attention");
    shut_stop_a: assert property (dc_wr && bus_wdata[DC_SHUT]
        && (bus_dev == own_dev || bus_dev == DEVNUM_BCAST) |-> ##3 !conv_active [*3])
        else $error("conversion runs in shutdown");
    cover property (bus_rvalid);
    cover property (attn_req);
    cover property (conv_active ##1 !conv_active);
endmodule
bind tsrs_regs tsrs_regs_chk u_tsrs_regs_chk (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .addr_pin_high(addr_pin_high), .addr_pin_low(addr_pin_low), .bus_dev(bus_dev),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_ack_ok(bus_ack_ok), .bus_ack_err(bus_ack_err), .bus_idle(bus_idle),
    .sensor_code(sensor_code), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .attn_req(attn_req), .conv_active(conv_active), .low_speed(low_speed));

// ### tb_top.sv
// Self-checking bench for the temperature sensor register set
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h expected %h", $time, g, e); end end
module tb_top;
    import tsrs_pkg::*;
    localparam logic [2:0] DEV = 3'h3;
    localparam logic [5:0] RA [10] = '{REG_DEVNUM, REG_MAKER, REG_PART, REG_FUNCCAP,
        REG_STATUS, REG_DEVCTL, REG_TEMPCAP, REG_RESULT, REG_TEMPCTL, REG_CONVRATE};
    localparam logic [15:0] RV [10] = '{16'h0003, 16'h3c3c, 16'h32a5, 16'h0001, 16'h0000,
        16'h0000, 16'h014a, 16'h0000, 16'h0000, 16'h0002};
    localparam logic [15:0] TC [4] = '{16'h0010, 16'h0010, 16'h0014, 16'h0014};
    localparam logic [15:0] TR [4] = '{16'h0000, 16'h0003, 16'h0001, 16'h0003};
    localparam logic [4:0]  DREV = 5'h06;
    localparam logic [10:0] PCODE = 11'h2a5;  // Arbitrary value
    localparam logic [15:0] MCODE = 16'h3c3c; // Arbitrary value
    localparam int          CL [8] = '{40, 50, 64, 80, 50, 100, 110, 120};
    localparam int          TL [4] = '{40, 80, 100, 120};
    logic        mclk, arst_n, bus_wr, bus_rd, bus_ack_ok, bus_ack_err, bus_idle;
    logic        clk_en, addr_pin_high, addr_pin_low;
    logic        bus_rvalid, attn_req, conv_active, low_speed, v;
    logic [2:0]  bus_dev;
    logic [5:0]  bus_addr;
    logic [9:0]  sensor_code;
    logic [15:0] bus_wdata, bus_rdata, d;
    int          miscompares, num_checks, n;
    int          attn_cnt = 0;
    int          attn_was;
    tsrs_regs #(.DIE_REVISION(DREV), .PART_CODE(PCODE), .MAKER_CODE(MCODE),
        .CONV_MS_00_P(CL[0]), .CONV_MS_01_P(CL[1]), .CONV_MS_10_P(CL[2]),
        .CONV_MS_11_P(CL[3]), .CONV_L00_P(CL[4]), .CONV_L01_P(CL[5]),
        .CONV_L10_P(CL[6]), .CONV_L11_P(CL[7]))
    u_tsrs_regs (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
        .addr_pin_high(addr_pin_high), .addr_pin_low(addr_pin_low),
        .bus_dev(bus_dev), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_ack_ok(bus_ack_ok), .bus_ack_err(bus_ack_err),
        .bus_idle(bus_idle), .sensor_code(sensor_code), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .attn_req(attn_req), .conv_active(conv_active),
        .low_speed(low_speed));
    tsrs_master u_tsrs_master (.mclk(mclk), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .bus_dev(bus_dev), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_ack_ok(bus_ack_ok), .bus_ack_err(bus_ack_err),
        .bus_idle(bus_idle));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Counts pulses so a suppressed request can be checked over a span
    always @(posedge mclk)
        if (attn_req === 1'b1)
            attn_cnt <= attn_cnt + 1;
    task automatic results();
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_rd(input logic [5:0] a, input logic [15:0] e);
        u_tsrs_master.rd(DEV, a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask
    // Bounded wait; n counts edges up to the attention pulse
    task automatic wait_attn();
        n = 0;
        #1;
        // Pulse may already stand when called right at its launching edge
        while (attn_req !== 1'b1 && n < 3000)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 3000)
        begin
            miscompares++;
            results();
        end
    endtask
    task automatic wr(input logic [2:0] dv, input logic [5:0] a, input logic [15:0] w);
        u_tsrs_master.wr(dv, a, w, 1'b1);
    endtask
    initial
    begin
        miscompares = 0;
        num_checks = 0;
        arst_n = 1'b0;
        clk_en = 1'b1;
        addr_pin_high = 1'b1;
        addr_pin_low = 1'b0;
        sensor_code = 10'h3fc;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 10; i++) chk_rd(RA[i], RV[i]);
        `CHK(conv_active, 1'b0)
        u_tsrs_master.berr();
        wait_attn();
        `CHK(n <= 3, 1'b1)
        chk_rd(REG_STATUS, 16'h0080);
        chk_rd(REG_STATUS, 16'h0000);
        u_tsrs_master.rd(DEVNUM_BCAST, REG_STATUS, d, v);
        `CHK(v, 1'b0)
        u_tsrs_master.rd(3'h1, REG_STATUS, d, v);
        `CHK(v, 1'b0)
        wr(DEVNUM_BCAST, REG_TEMPCTL, 16'h0003);
        u_tsrs_master.wr(DEV, REG_TEMPCTL, 16'h0003, 1'b0);
        chk_rd(REG_TEMPCTL, 16'h0000);
        wr(DEVNUM_BCAST, REG_DEVCTL, 16'h0016);
        chk_rd(REG_DEVCTL, 16'h0002);
        wr(DEV, REG_DEVCTL, 16'h0000);
        wr(DEV, REG_TEMPCTL, 16'hffff);
        chk_rd(REG_TEMPCTL, 16'h0003);
        wr(DEV, REG_CONVRATE, 16'h0000);
        wr(DEV, REG_TEMPCTL, 16'h0001);
        chk_rd(REG_TEMPCTL, 16'h0001);
        wr(DEV, REG_DEVCTL, 16'h0010);
        repeat (60) @(posedge mclk);
        #1;
        `CHK(conv_active, 1'b0)
        wr(DEV, REG_TEMPCTL, 16'h0003);
        wait_attn();
        `CHK(n <= 45, 1'b1)
        chk_rd(REG_STATUS, 16'h0001);
        chk_rd(REG_RESULT, 16'hff00);
        chk_rd(REG_STATUS, 16'h0000);
        @(posedge mclk);
        sensor_code <= 10'h270;
        // Two unread results in a row
        repeat (89) @(posedge mclk);
        chk_rd(REG_STATUS, 16'h0011);
        chk_rd(REG_RESULT, 16'h9c00);
        chk_rd(REG_STATUS, 16'h0000);
        // Busy link holds back conversion requests
        u_tsrs_master.idle(1'b0);
        attn_was = attn_cnt;
        repeat (100) @(posedge mclk);
        `CHK(attn_cnt == attn_was, 1'b1)
        u_tsrs_master.idle(1'b1);
        for (int i = 0; i < 4; i++)
        begin
            wr(DEV, REG_CONVRATE, TR[i]);
            wr(DEV, REG_DEVCTL, TC[i]);
            @(posedge mclk);
            #1;
            `CHK(low_speed, TC[i][2])
            u_tsrs_master.rd(DEV, REG_STATUS, d, v);
            wait_attn();
            u_tsrs_master.rd(DEV, REG_STATUS, d, v);
            wait_attn();
            `CHK(n + 2 >= TL[i] && n + 2 <= TL[i] + 2, 1'b1)
        end
        wr(DEV, REG_DEVCTL, 16'h0016);
        repeat (200) @(posedge mclk);
        #1;
        `CHK(conv_active, 1'b0)
        wr(DEV, REG_DEVCTL, 16'h0014);
        repeat (3) @(posedge mclk);
        #1;
        `CHK(conv_active, 1'b1)
        wr(DEV, REG_DEVCTL, 16'h0011);
        repeat (3) @(posedge mclk);
        for (int i = 4; i < 10; i++) chk_rd(RA[i], RV[i]);
        `CHK(conv_active, 1'b0)
        @(posedge mclk);
        addr_pin_low <= 1'b1;
        repeat (8) @(posedge mclk);
        // Write while frozen must not land
        clk_en <= 1'b0;
        u_tsrs_master.wr(3'h4, REG_CONVRATE, 16'h0001, 1'b1);
        clk_en <= 1'b1;
        u_tsrs_master.rd(3'h4, REG_DEVNUM, d, v);
        `CHK(v, 1'b1)
        `CHK(d, 16'h0004)
        u_tsrs_master.rd(3'h4, REG_CONVRATE, d, v);
        `CHK(d, 16'h0002)
        results();
    end
endmodule
